// ===== design/ibrc_defs.svh
`ifndef IBRC_DEFS_SVH
`define IBRC_DEFS_SVH
// Register byte offsets
`define IBRC_OFF_CTRL      12'h000
`define IBRC_OFF_STATUS    12'h004
`define IBRC_OFF_ROMADDR   12'h008
`define IBRC_OFF_ROMDATA   12'h00C
`define IBRC_OFF_BUSADDR   12'h010
`define IBRC_OFF_RXDATA    12'h014
`define IBRC_OFF_TXDATA    12'h018
`define IBRC_OFF_ADPSEL    12'h01C
`define IBRC_OFF_DUMP      12'h020
// Control register fields
`define IBRC_CTRL_DIR      0
`define IBRC_CTRL_UPPER_LO 1
`define IBRC_CTRL_UPPER_HI 3
`define IBRC_CTRL_LLO      4
`define IBRC_CTRL_EOI      5
`define IBRC_CTRL_SRQ      6
// Status register fields
`define IBRC_ST_ADDRESSED  0
`define IBRC_ST_REMOTE     1
`define IBRC_ST_RXVALID    2
`define IBRC_ST_TXBUSY     3
`define IBRC_ST_SELFTEST   4
`define IBRC_ST_DUMPBUSY   5
`define IBRC_ST_ATN        6
`define IBRC_ST_REN        7
// Reset values
`define IBRC_CTRL_RST      7'h00
`define IBRC_ROMADDR_RST   8'h00
// Timing: power-up strobe length and reset hold after supply recovers
`define IBRC_STROBE_NS     40
`define IBRC_STROBE_CYC    ((`IBRC_STROBE_NS + 3) / 4)
`define IBRC_HOLD_NS       400
`define IBRC_HOLD_CYC      ((`IBRC_HOLD_NS + 3) / 4)
// Checksum bias and dump length
`define IBRC_SUM_BIAS      8'hFF
`define IBRC_ROM_WORDS     2048
`endif

// ===== design/ibrc_pkg.sv
package ibrc_pkg;
    typedef enum logic [1:0] {HS_IDLE, HS_RDY, HS_ACC, HS_WAIT} ibrc_hs_t;
    typedef enum logic [1:0] {TK_IDLE, TK_WNRFD, TK_WNDAC, TK_REL} ibrc_tk_t;
    typedef enum logic [1:0] {PU_STROBE, PU_LOAD, PU_RUN} ibrc_pu_t;
    typedef struct packed {
        logic ren_n;
        logic ifc_n;
        logic atn_n;
        logic eoi_n;
        logic srq_n;
    } ibrc_ctl_t;
    typedef struct packed {
        logic dav_n;
        logic nrfd_n;
        logic ndac_n;
    } ibrc_hsk_t;
endpackage

// ===== design/ibrc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "ibrc_defs.svh"
module ibrc_top
    import ibrc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        supply_ok,
    input  wire logic        test_mode_n,
    input  wire logic [7:0]  addr_switch,
    input  wire logic        key_local,
    input  wire logic        key_other,
    output logic             key_local_act,
    output logic             key_other_act,
    output logic             proc_reset_n,
    output logic             switch_common_strobe_n,
    output logic             self_test_run,
    output logic             irq,
    output logic [10:0]      rom_address_lines,
    output logic             rom_enable,
    input  wire logic [7:0]  rom_data,
    output logic [7:0]       rom_bus_data,
    output logic             rom_bus_drive,
    output logic [2:0]       adapter_register_select,
    output logic             transmit_direction_select,
    input  wire logic [7:0]  dio_n_i,
    output logic [7:0]       dio_n_o,
    output logic             dio_oe,
    input  wire ibrc_ctl_t   ctl_i,
    output ibrc_ctl_t        ctl_o,
    output logic             eoi_oe,
    output logic             srq_oe,
    input  wire ibrc_hsk_t   hsk_i,
    output ibrc_hsk_t        hsk_o,
    output logic             dav_oe,
    output logic             lsn_oe,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a[11:2] <= (`IBRC_OFF_DUMP >> 2)) && (a[1:0] == 2'b00);
endfunction

////////////////////////////////////////////////////////////////////////////////
// State
logic [6:0]  ctrl_r, ctrl_nxt;
logic [7:0]  romaddr_r, romaddr_nxt;
logic [7:0]  busaddr_r, busaddr_nxt;
logic        selftest_r, selftest_nxt;
ibrc_pu_t    pu_r, pu_nxt;
logic [7:0]  pucnt_r, pucnt_nxt;
logic [7:0]  holdcnt_r, holdcnt_nxt;
logic        preset_r, preset_nxt;
logic        addressed_r, addressed_nxt;
logic        remote_r, remote_nxt;
logic        irq_r, irq_nxt;
logic [7:0]  rx_r, rx_nxt;
logic        rxv_r, rxv_nxt;
logic [7:0]  tx_r, tx_nxt;
logic        txeoi_r, txeoi_nxt;
ibrc_hs_t    hs_r, hs_nxt;
ibrc_tk_t    tk_r, tk_nxt;
logic        dump_r, dump_nxt;
logic [10:0] dcnt_r, dcnt_nxt;
logic        romen_r, romen_nxt;
logic [7:0]  romq_r, romq_nxt;
logic        romdrv_r, romdrv_nxt;
logic [7:0]  sum_r, sum_nxt;
logic        sel_en_r, sel_en_nxt;
logic [2:0]  sel_r, sel_nxt;
logic        aw_r, aw_nxt, w_r, w_nxt;
logic [11:0] awa_r, awa_nxt;
logic [31:0] wd_r, wd_nxt;
logic        bv_r, bv_nxt, rv_r, rv_nxt, arr_r, arr_nxt;
logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
logic [31:0] rd_r, rd_nxt;
logic        kl_r, kl_nxt, ko_r, ko_nxt;

logic        atn, dav, nrfd, ndac, take_part, wr_fire, rd_fire, dump_load;
logic [7:0]  dio;

////////////////////////////////////////////////////////////////////////////////
// Combinational next state
always_comb
begin
    // Bus lines are low-true
    // Active low lines
    atn  = ~ctl_i.atn_n;
    dav  = ~hsk_i.dav_n;
    nrfd = ~hsk_i.nrfd_n;
    ndac = ~hsk_i.ndac_n;
    dio  = ~dio_n_i;
    ctrl_nxt = ctrl_r;
    romaddr_nxt = romaddr_r;
    busaddr_nxt = busaddr_r;
    selftest_nxt = selftest_r;
    pu_nxt = pu_r;
    pucnt_nxt = pucnt_r;
    holdcnt_nxt = holdcnt_r;
    preset_nxt = preset_r;
    addressed_nxt = addressed_r;
    remote_nxt = remote_r;
    irq_nxt = 1'b0;
    rx_nxt = rx_r;
    rxv_nxt = rxv_r;
    tx_nxt = tx_r;
    txeoi_nxt = txeoi_r;
    hs_nxt = hs_r;
    tk_nxt = tk_r;
    dump_nxt = dump_r;
    dcnt_nxt = dcnt_r;
    romen_nxt = 1'b0;
    romq_nxt = romq_r;
    romdrv_nxt = romdrv_r;
    sum_nxt = sum_r;
    sel_en_nxt = sel_en_r;
    sel_nxt = sel_r;
    aw_nxt = aw_r;
    w_nxt = w_r;
    awa_nxt = awa_r;
    wd_nxt = wd_r;
    bv_nxt = bv_r;
    br_nxt = br_r;
    rv_nxt = rv_r;
    rr_nxt = rr_r;
    rd_nxt = rd_r;
    arr_nxt = 1'b0;
    kl_nxt = key_local & ~(remote_r & ctrl_r[`IBRC_CTRL_LLO]);
    ko_nxt = key_other & ~remote_r;

    if (!supply_ok)
    begin
        preset_nxt = 1'b1;
        holdcnt_nxt = 8'(`IBRC_HOLD_CYC);
    end
    else if (holdcnt_r != 8'h00)
        holdcnt_nxt = holdcnt_r - 8'h01;
    else
        preset_nxt = 1'b0;

    unique case (pu_r)
        PU_STROBE:
        begin
            if (pucnt_r == 8'h00)
                pu_nxt = PU_LOAD;
            else
                pucnt_nxt = pucnt_r - 8'h01;
        end
        PU_LOAD:
        begin
            busaddr_nxt = addr_switch;
            selftest_nxt = ~test_mode_n;
            pu_nxt = PU_RUN;
        end
        PU_RUN:
        begin
        end
    endcase

    // AXI write side takes address and data in either order
    wr_fire = aw_r && w_r && !bv_r;
    if (s_axi_awvalid && s_axi_awready)
    begin
        aw_nxt = 1'b1;
        awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
        w_nxt = 1'b1;
        wd_nxt = s_axi_wdata;
    end
    if (wr_fire)
    begin
        aw_nxt = 1'b0;
        w_nxt = 1'b0;
        bv_nxt = 1'b1;
        br_nxt = is_mapped(awa_r) ? 2'b00 : 2'b10;
        if (wd_r[0] | s_axi_wstrb[0] | 1'b1)
        begin
            unique case (awa_r)
                `IBRC_OFF_CTRL: ctrl_nxt = wd_r[6:0];
                `IBRC_OFF_ROMADDR: romaddr_nxt = wd_r[7:0];
                `IBRC_OFF_ROMDATA: romen_nxt = 1'b1;
                `IBRC_OFF_TXDATA:
                begin
                    tx_nxt = wd_r[7:0];
                    txeoi_nxt = wd_r[8];
                    if (tk_r == TK_IDLE)
                        tk_nxt = TK_WNRFD;
                end
                `IBRC_OFF_ADPSEL: sel_nxt = wd_r[2:0];
                `IBRC_OFF_DUMP:
                begin
                    dump_nxt = 1'b1;
                    dcnt_nxt = 11'h000;
                    sum_nxt = `IBRC_SUM_BIAS;
                end
                default:
                begin
                end
            endcase
        end
    end
    if (bv_r && s_axi_bready)
        bv_nxt = 1'b0;

    // AXI read side
    rd_fire = s_axi_arvalid && !rv_r && !arr_r;
    if (rd_fire)
    begin
        arr_nxt = 1'b1;
        rv_nxt = 1'b1;
        rr_nxt = is_mapped(s_axi_araddr) ? 2'b00 : 2'b10;
        rd_nxt = 32'h00000000;
        unique case (s_axi_araddr)
            `IBRC_OFF_CTRL: rd_nxt = {25'h0, ctrl_r};
            `IBRC_OFF_STATUS:
                rd_nxt = {24'h0, ~ctl_i.ren_n, atn, dump_r, selftest_r,
                          tk_r != TK_IDLE, rxv_r, remote_r, addressed_r};
            `IBRC_OFF_ROMADDR: rd_nxt = {24'h0, romaddr_r};
            `IBRC_OFF_ROMDATA: rd_nxt = {24'h0, romq_r};
            `IBRC_OFF_BUSADDR: rd_nxt = {24'h0, busaddr_r};
            `IBRC_OFF_RXDATA:
            begin
                rd_nxt = {24'h0, rx_r};
                rxv_nxt = 1'b0;
            end
            `IBRC_OFF_DUMP: rd_nxt = {24'h0, sum_r};
            default:
            begin
            end
        endcase
    end
    if (rv_r && s_axi_rready)
        rv_nxt = 1'b0;

    if (atn && hs_r == HS_RDY && dav)
    begin
        if (dio[4:0] == busaddr_r[4:0] && dio[6:5] != 2'b11)
        begin
            if (!addressed_r)
                irq_nxt = 1'b1;
            addressed_nxt = 1'b1;
            remote_nxt = remote_r | ~ctl_i.ren_n;
            sel_en_nxt = 1'b1;
        end
        else if (dio[6:0] == 7'h3F)
            addressed_nxt = 1'b0;
    end
    // Clear outranks a same-cycle address match
    if (!ctl_i.ifc_n)
    begin
        addressed_nxt = 1'b0;
        irq_nxt = 1'b0;
    end
    if (ctl_i.ren_n)
        remote_nxt = 1'b0;

    take_part = atn || (addressed_r && !transmit_direction_select);
    unique case (hs_r)
        HS_IDLE: if (take_part) hs_nxt = HS_RDY;
        HS_RDY:
        begin
            // Drop out once no longer a party, so foreign bytes are not held up
            if (!take_part)
                hs_nxt = HS_IDLE;
            else if (dav)
                hs_nxt = HS_ACC;
        end
        HS_ACC:
        begin
            if (!atn)
            begin
                rx_nxt = dio;
                rxv_nxt = 1'b1;
            end
            hs_nxt = HS_WAIT;
        end
        HS_WAIT: if (!dav) hs_nxt = take_part ? HS_RDY : HS_IDLE;
    endcase

    unique case (tk_r)
        TK_IDLE:  tk_nxt = tk_nxt;
        TK_WNRFD: if (!nrfd && !atn) tk_nxt = TK_WNDAC;
        TK_WNDAC: if (!ndac) tk_nxt = TK_REL;
        TK_REL:   tk_nxt = TK_IDLE;
    endcase

    // Dump stream feeds talker
    // Each byte address goes through the latch, as a processor write would
    dump_load = dump_r && tk_r == TK_IDLE && !wr_fire && !romen_r;
    if (dump_r && tk_r == TK_IDLE && !wr_fire)
    begin
        romen_nxt = 1'b1;
        if (romen_r)
        begin
            tx_nxt = rom_data;
            sum_nxt = sum_r + rom_data;
            txeoi_nxt = (dcnt_r == 11'(`IBRC_ROM_WORDS - 1));
            tk_nxt = TK_WNRFD;
            romen_nxt = 1'b0;
            dcnt_nxt = dcnt_r + 11'h001;
            if (dcnt_r == 11'(`IBRC_ROM_WORDS - 1))
                dump_nxt = 1'b0;
        end
        else
        begin
            romaddr_nxt = dcnt_r[7:0];
            ctrl_nxt[`IBRC_CTRL_UPPER_HI:`IBRC_CTRL_UPPER_LO] = dcnt_r[10:8];
        end
    end
    if (romen_r)
    begin
        romq_nxt = rom_data;
        romdrv_nxt = 1'b1;
    end
    else
        romdrv_nxt = 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// Registers
always_ff @(posedge aclk)
begin
    if (!aresetn)
    begin
        ctrl_r <= `IBRC_CTRL_RST;
        romaddr_r <= `IBRC_ROMADDR_RST;
        busaddr_r <= 8'h00;
        selftest_r <= 1'b0;
        pu_r <= PU_STROBE;
        pucnt_r <= 8'(`IBRC_STROBE_CYC);
        holdcnt_r <= 8'(`IBRC_HOLD_CYC);
        preset_r <= 1'b1;
        addressed_r <= 1'b0;
        remote_r <= 1'b0;
        irq_r <= 1'b0;
        rx_r <= 8'h00;
        rxv_r <= 1'b0;
        tx_r <= 8'h00;
        txeoi_r <= 1'b0;
        hs_r <= HS_IDLE;
        tk_r <= TK_IDLE;
        dump_r <= 1'b0;
        dcnt_r <= 11'h000;
        romen_r <= 1'b0;
        romq_r <= 8'h00;
        romdrv_r <= 1'b0;
        sum_r <= 8'h00;
        sel_en_r <= 1'b0;
        sel_r <= 3'h0;
        aw_r <= 1'b0;
        w_r <= 1'b0;
        awa_r <= 12'h000;
        wd_r <= 32'h00000000;
        bv_r <= 1'b0;
        br_r <= 2'b00;
        rv_r <= 1'b0;
        rr_r <= 2'b00;
        rd_r <= 32'h00000000;
        arr_r <= 1'b0;
        kl_r <= 1'b0;
        ko_r <= 1'b0;
    end
    else
    begin
        ctrl_r <= ctrl_nxt;
        romaddr_r <= romaddr_nxt;
        busaddr_r <= busaddr_nxt;
        selftest_r <= selftest_nxt;
        pu_r <= pu_nxt;
        pucnt_r <= pucnt_nxt;
        holdcnt_r <= holdcnt_nxt;
        preset_r <= preset_nxt;
        addressed_r <= addressed_nxt;
        remote_r <= remote_nxt;
        irq_r <= irq_nxt;
        rx_r <= rx_nxt;
        rxv_r <= rxv_nxt;
        tx_r <= tx_nxt;
        txeoi_r <= txeoi_nxt;
        hs_r <= hs_nxt;
        tk_r <= tk_nxt;
        dump_r <= dump_nxt;
        dcnt_r <= dcnt_nxt;
        romen_r <= romen_nxt;
        romq_r <= romq_nxt;
        romdrv_r <= romdrv_nxt;
        sum_r <= sum_nxt;
        sel_en_r <= sel_en_nxt;
        sel_r <= sel_nxt;
        aw_r <= aw_nxt;
        w_r <= w_nxt;
        awa_r <= awa_nxt;
        wd_r <= wd_nxt;
        bv_r <= bv_nxt;
        br_r <= br_nxt;
        rv_r <= rv_nxt;
        rr_r <= rr_nxt;
        rd_r <= rd_nxt;
        arr_r <= arr_nxt;
        kl_r <= kl_nxt;
        ko_r <= ko_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Outputs, all from flip-flops
assign s_axi_awready = !aw_r;
assign s_axi_wready  = !w_r;
assign s_axi_bvalid  = bv_r;
assign s_axi_bresp   = br_r;
assign s_axi_arready = arr_r;
assign s_axi_rvalid  = rv_r;
assign s_axi_rresp   = rr_r;
assign s_axi_rdata   = rd_r;
assign proc_reset_n  = !preset_r;
assign switch_common_strobe_n = !(pu_r == PU_STROBE);
assign self_test_run = selftest_r;
assign irq = irq_r;
assign rom_address_lines = {ctrl_r[`IBRC_CTRL_UPPER_HI:`IBRC_CTRL_UPPER_LO], romaddr_r};
assign rom_enable = romen_r;
assign rom_bus_data = romq_r;
assign rom_bus_drive = romdrv_r;
assign adapter_register_select = sel_en_r ? sel_r : 3'h0;
assign transmit_direction_select = ctrl_r[`IBRC_CTRL_DIR];
assign dio_n_o = ~tx_r;
assign dio_oe  = transmit_direction_select && tk_r != TK_IDLE;
assign dav_oe  = tk_r == TK_WNDAC;
assign lsn_oe  = !transmit_direction_select;
// EOI on last byte when attention off
assign eoi_oe  = tk_r == TK_WNDAC && txeoi_r;
assign srq_oe  = ctrl_r[`IBRC_CTRL_SRQ];
assign ctl_o   = '{ren_n: 1'b1, ifc_n: 1'b1, atn_n: 1'b1, eoi_n: 1'b0, srq_n: 1'b0};
// Idle releases both lines; NRFD falls before NDAC is released
assign hsk_o   = '{dav_n: 1'b0, nrfd_n: hs_r == HS_RDY || hs_r == HS_IDLE,
                   ndac_n: hs_r == HS_WAIT || hs_r == HS_IDLE};
assign key_local_act = kl_r;
assign key_other_act = ko_r;

////////////////////////////////////////////////////////////////////////////////
// Checks
sequence s_dav_taken;
    hs_r == HS_RDY && dav && take_part;
endsequence
chk_ndac_release: assert property (@(posedge aclk) disable iff (!aresetn)
    s_dav_taken |=> hs_r == HS_ACC ##1 hs_r == HS_WAIT)
    else $error("listener sequence broken");
chk_reset_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !supply_ok |=> !proc_reset_n)
    else $error("reset not held on supply loss");
chk_latch_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    !(wr_fire && awa_r == `IBRC_OFF_ROMADDR) && !dump_load |=> $stable(romaddr_r))
    else $error("rom address latch changed");
chk_addr_once: assert property (@(posedge aclk) disable iff (!aresetn)
    pu_r == PU_RUN |=> $stable(busaddr_r))
    else $error("bus address changed after power-up");
chk_irq_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_r |-> addressed_r)
    else $error("interrupt without address");
chk_dav_order: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(dav_oe) |-> $past(tk_r) == TK_WNRFD && dio_oe)
    else $error("dav before data");
chk_rom_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    rom_bus_drive |-> $past(romen_r))
    else $error("rom drove bus without enable");
chk_key_lock: assert property (@(posedge aclk) disable iff (!aresetn)
    remote_r && key_other |=> !key_other_act)
    else $error("key accepted in remote");
endmodule
`default_nettype wire

// ===== tb/ibrc_ctlr_model.sv
`timescale 1ns/10ps
`default_nettype none
module ibrc_ctlr_model
(
    input  wire logic       aclk,
    input  wire logic       dav_w,
    input  wire logic       nrfd_w,
    input  wire logic       ndac_w,
    input  wire logic [7:0] dio_n_i,
    output var logic        p_dav,
    output var logic        p_nrfd,
    output var logic        p_ndac,
    output var logic        p_atn,
    output var logic [7:0]  p_dio
);
    wire logic [2:0] hs = {ndac_w, nrfd_w, dav_w};
    // Released lines float high on the pull-ups
    initial {p_dav, p_nrfd, p_ndac, p_atn, p_dio} = 12'hFFF;
    ////////////////////////////////////////
    task automatic wt(input int s, input logic v, inout bit ok);
        int n;
        for (n = 0; n < 3000 && hs[s] !== v; n++)
            @(posedge aclk);
        ok &= (n < 3000);
    endtask
    task automatic send(input logic [7:0] b, input logic atn, output bit ok);
        ok = 1'b1;
        @(posedge aclk);
        p_atn <= ~atn;
        repeat (4) @(posedge aclk);
        wt(1, 1'b1, ok);
        wt(2, 1'b0, ok);
        p_dio <= ~b;
        @(posedge aclk);
        p_dav <= 1'b0;
        wt(2, 1'b1, ok);
        p_dav <= 1'b1;
        p_dio <= 8'hFF;
    endtask
    task automatic hold();
        @(posedge aclk);
        p_nrfd <= 1'b0;
        p_ndac <= 1'b0;
    endtask
    task automatic recv(output logic [7:0] b, output bit ok);
        ok = 1'b1;
        @(posedge aclk);
        p_nrfd <= 1'b1;
        wt(0, 1'b0, ok);
        b = ~dio_n_i;
        p_nrfd <= 1'b0;
        @(posedge aclk);
        p_ndac <= 1'b1;
        wt(0, 1'b1, ok);
        p_ndac <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_instrument_bus_rom_control.sv
`timescale 1ns/10ps
`default_nettype none
`include "ibrc_defs.svh"
module tb_instrument_bus_rom_control;
    import ibrc_pkg::*;
    logic aclk, aresetn, supply_ok, test_mode_n, key_local, key_other, irq;
    logic key_local_act, key_other_act, proc_reset_n, switch_common_strobe_n;
    logic self_test_run, rom_enable, rom_bus_drive, transmit_direction_select;
    logic dio_oe, eoi_oe, srq_oe, dav_oe, lsn_oe, p_dav, p_nrfd, p_ndac, p_atn;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
    logic [2:0] adapter_register_select;
    logic [3:0] s_axi_wstrb;
    logic [7:0] addr_switch, rom_data, rom_bus_data, dio_n_o, p_dio;
    logic [10:0] rom_address_lines;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rs, rdat;
    ibrc_ctl_t ctl_i, ctl_o;
    ibrc_hsk_t hsk_i, hsk_o;
    int mismatches, compares, irqs, eois;
    function automatic logic [7:0] rom_f(input logic [10:0] a);
        return a[7:0] ^ {a[10:8], 5'h13};
    endfunction
    // Wired AND of both parties on the open-drain lines
    wire logic dav_w = (dav_oe ? hsk_o.dav_n : 1'b1) & p_dav;
    wire logic nrfd_w = (lsn_oe ? hsk_o.nrfd_n : 1'b1) & p_nrfd;
    wire logic ndac_w = (lsn_oe ? hsk_o.ndac_n : 1'b1) & p_ndac;
    wire logic [7:0] dio_n_i = (dio_oe ? dio_n_o : 8'hFF) & p_dio;
    assign ctl_i = {2'b01, p_atn, (eoi_oe ? ctl_o.eoi_n : 1'b1), (srq_oe ? ctl_o.srq_n : 1'b1)};
    assign hsk_i = {dav_w, nrfd_w, ndac_w};
    // Deselected ROM shows the inverse so a stale byte cannot pass
    assign rom_data = rom_enable ? rom_f(rom_address_lines) : ~rom_f(rom_address_lines);
    ibrc_top uut (.*);
    ibrc_ctlr_model ctl (.*);
    always #2 aclk = ~aclk;
    always @(posedge aclk) irqs <= irqs + int'(irq === 1'b1);
    always @(posedge aclk) eois <= eois + int'(eoi_oe === 1'b1);
    ////////////////////////////////////////
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    task automatic stop_test();
        if (mismatches == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic to_chk(input bit late);
        if (late)
        begin
            mismatches++;
            stop_test();
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task automatic rst(input logic tm);
        @(posedge aclk);
        aresetn <= 1'b0;
        test_mode_n <= tm;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid)
                break;
        end
        s_axi_bready <= 1'b0;
        to_chk(n == 100);
        #1;
    endtask
    task automatic rd(input logic [11:0] a);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
                break;
        end
        rdat = s_axi_rdata;
        rrsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        to_chk(n == 100);
        #1;
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        chk(rdat & m, e);
    endtask
    ////////////////////////////////////////
    initial
    begin
        logic [31:0] v;
        logic [7:0] b;
        bit ok;
        int i, s;
        {aclk, aresetn, key_local, key_other, s_axi_awvalid, s_axi_wvalid} = 6'h00;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
        {supply_ok, test_mode_n, s_axi_wstrb} = 6'h3F;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        addr_switch = 8'h05;
        rs = 32'h62;
        rst(1'b1);
        cyc(1);
        chk(32'(switch_common_strobe_n), 32'h0);
        cyc(20);
        chk(32'(switch_common_strobe_n), 32'h1);
        chk(32'(self_test_run), 32'h0);
        rc(`IBRC_OFF_BUSADDR, 32'hFF, 32'h05);
        @(posedge aclk);
        addr_switch <= 8'h0A;
        rc(`IBRC_OFF_BUSADDR, 32'hFF, 32'h05);
        rd(12'h040);
        chk(32'(rrsp), 32'h2);
        chk(rdat, 32'h0);
        for (i = 0; i < 4; i++)
        begin
            v = xs();
            wr(`IBRC_OFF_CTRL, {28'h0, v[10:8], 1'b0});
            wr(`IBRC_OFF_ROMADDR, {24'h0, v[7:0]});
            chk(32'(rom_address_lines), 32'(v[10:0]));
            wr(`IBRC_OFF_ROMDATA, v);
            rc(`IBRC_OFF_ROMDATA, 32'hFF, 32'(rom_f(v[10:0])));
            chk(32'(rom_bus_data), 32'(rom_f(v[10:0])));
            chk(32'(rom_address_lines), 32'(v[10:0]));
        end
        @(posedge aclk);
        {key_local, key_other} <= 2'b11;
        wr(`IBRC_OFF_ADPSEL, 32'h5);
        chk(32'({key_local_act, key_other_act}), 32'h3);
        chk(32'(adapter_register_select), 32'h0);
        chk(32'(transmit_direction_select), 32'h0);
        ctl.send(8'h3F, 1'b1, ok);
        to_chk(!ok);
        ctl.send(8'h25, 1'b1, ok);
        to_chk(!ok);
        cyc(4);
        chk(32'(irqs), 32'h1);
        chk(32'(adapter_register_select), 32'h5);
        rc(`IBRC_OFF_STATUS, 32'h3, 32'h3);
        chk(32'({key_local_act, key_other_act}), 32'h2);
        v = xs();
        ctl.send(v[7:0], 1'b0, ok);
        to_chk(!ok);
        rc(`IBRC_OFF_RXDATA, 32'hFF, 32'(v[7:0]));
        wr(`IBRC_OFF_CTRL, 32'h11);
        chk(32'(transmit_direction_select), 32'h1);
        chk(32'(key_local_act), 32'h0);
        ctl.hold();
        wr(`IBRC_OFF_DUMP, 32'h1);
        s = 255;
        for (i = 0; i < 2048; i++)
        begin
            if (i == 2047)
                chk(32'(eois), 32'h0);
            ctl.recv(b, ok);
            to_chk(!ok);
            chk(32'(b), 32'(rom_f(i[10:0])));
            s += rom_f(i[10:0]);
        end
        chk(32'(eois != 0), 32'h1);
        cyc(4);
        rc(`IBRC_OFF_DUMP, 32'hFF, 32'(s % 256));
        @(posedge aclk);
        supply_ok <= 1'b0;
        cyc(3);
        chk(32'(proc_reset_n), 32'h0);
        @(posedge aclk);
        supply_ok <= 1'b1;
        cyc(96);
        chk(32'(proc_reset_n), 32'h0);
        cyc(8);
        chk(32'(proc_reset_n), 32'h1);
        rst(1'b1);
        cyc(30);
        rc(`IBRC_OFF_BUSADDR, 32'hFF, 32'h0A);
        rst(1'b0);
        cyc(30);
        chk(32'(self_test_run), 32'h1);
        stop_test();
    end
endmodule
`default_nettype wire
